// ---- rtl/srbc_core.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Sensor readout and boost control
// ****************************************************************
// Behaviour
// - One 12-bit converter shared by two sensors
// - Results averaged over 134 ms window
// - Control bit 5 picks readout sensor
// - Control bit 4 picks compensation sensor
// - Control bit 3 switches active load
// - Control bit 2 manual versus adaptive voltage
// - Control bit 1 standby versus run when bit 0 is set
// - Fixed 1 MHz switching, minimum pulse
// - Manual voltage from binary code, 16 levels
// - Digital switch duty limit
// - Overcurrent ends switch pulse for cycle
// - Open feedback inhibits switching
// - LED PWM cycle 820 us from clock
// - Fast PWM gives sixteen pulses per cycle
// - 50 ms low-current start on run
// - Voltage codes clamp to 5..20
// - Adaptive voltage selected after reset
module srbc_core
  import srbc_pkg::*;
#(
  parameter int AVG_WIN = AVG_WIN_CYC,        // Averaging window in cycles
  parameter int SOFT_LEN = SOFT_CYC,          // Low-current start in cycles
  parameter int PWM_LEN = PWM_CYCLE_CYC       // LED PWM cycle in cycles
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic adc_start,
  output logic adc_input_select,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output logic [11:0] comp_value,
  input wire srbc_boost_in_t boost_pins,
  output logic boost_switch,
  output logic boost_low_current,
  output logic autoload_on,
  output logic vout_adaptive,
  output logic [4:0] vout_code,
  input wire logic pwm_fast,
  output logic pwm_cycle_start,
  output logic pwm_pulse_start
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  srbc_ctrl_t ctrl_q;            // Control register
  logic [4:0] boost_code_q;      // Manual voltage code as written
  logic [7:0] lower_hold_q;      // Lower byte captured at upper read
  logic [7:0] rdata_q;           // Read data

  // Register writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CONTROL_RESET;
      boost_code_q <= BOOST_OUTPUT_RESET;
    end else if (reg_wr) begin
      if (reg_addr == MEASURE_BOOST_CONTROL_ADDR) begin
        ctrl_q <= reg_wdata;
      end else if (reg_addr == BOOST_OUTPUT_ADDR) begin
        boost_code_q <= reg_wdata[4:0];
      end
    end
  end

  // ****************************************************************
  // Conversion scheduling and averaging
  // ****************************************************************
  localparam int SMP_CYC = AVG_WIN / (2 * AVG_SAMPLES);
  logic [31:0] smp_cnt_q;        // Time to next conversion
  logic sel_q;                   // Sensor now being converted
  logic start_q;                 // Start pulse to the converter
  logic [11:0] avg_one;          // Averaged result, sensor one
  logic [11:0] avg_two;          // Averaged result, sensor two
  logic [11:0] readout;          // Result chosen for readout

  // Alternate the single converter between the sensors at a fixed pace
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      smp_cnt_q <= 32'h0000_0000;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (smp_cnt_q == 32'(SMP_CYC - 1)) begin
        smp_cnt_q <= 32'h0000_0000;
        start_q <= 1'b1;
      end else begin
        smp_cnt_q <= smp_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Channel toggles once each result is in, so samples never mix
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_q <= 1'b0;
    end else if (adc_done) begin
      sel_q <= ~sel_q;
    end
  end

  assign adc_start = start_q;
  assign adc_input_select = sel_q;

  // One averager per sensor; 64 samples each span the window
  srbc_avg u_avg_one (
    .sys_clk(sys_clk),
    .rst(rst),
    .smp_valid(adc_done & ~sel_q),
    .smp_data(adc_data),
    .avg_q(avg_one)
  );
  srbc_avg u_avg_two (
    .sys_clk(sys_clk),
    .rst(rst),
    .smp_valid(adc_done & sel_q),
    .smp_data(adc_data),
    .avg_q(avg_two)
  );

  // Readout and compensation sources chosen independently
  assign readout = ctrl_q.readout_channel_select ? avg_two : avg_one;
  assign comp_value = ctrl_q.compensation_source_choice ? avg_two : avg_one;

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Upper read freezes the lower byte; hosts must read upper first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
      lower_hold_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        MEASURE_BOOST_CONTROL_ADDR: begin
          rdata_q <= ctrl_q;
        end
        BOOST_OUTPUT_ADDR: begin
          rdata_q <= {3'h0, boost_code_q};
        end
        CONV_UPPER_ADDR: begin
          rdata_q <= {4'h0, readout[11:8]};
          lower_hold_q <= readout[7:0];
        end
        CONV_LOWER_ADDR: begin
          rdata_q <= lower_hold_q;
        end
        default: begin
          rdata_q <= 8'h00;                          // Unmapped reads as zero
        end
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************************************
  // Boost mode and voltage setting
  // ****************************************************************
  typedef enum logic [2:0] {
    BST_OFF = 3'b001,
    BST_SOFT = 3'b010,
    BST_RUN = 3'b100
  } srbc_bst_t;

  srbc_bst_t bst_q;              // Boost operating state
  logic [31:0] soft_cnt_q;       // Time spent in low-current start
  logic [4:0] code_clamped;      // Voltage code after clamping
  logic boost_en;                // Run bit and chip active together

  assign boost_en = ctrl_q.boost_run & ctrl_q.chip_active;

  // Standby drops straight to off; run starts gently
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bst_q <= BST_OFF;
      soft_cnt_q <= 32'h0000_0000;
    end else if (!boost_en) begin
      bst_q <= BST_OFF;
      soft_cnt_q <= 32'h0000_0000;
    end else begin
      unique case (bst_q)
        BST_OFF: begin
          bst_q <= BST_SOFT;
        end
        BST_SOFT: begin
          if (soft_cnt_q == 32'(SOFT_LEN - 1)) begin
            bst_q <= BST_RUN;
          end else begin
            soft_cnt_q <= soft_cnt_q + 32'h0000_0001;
          end
        end
        BST_RUN: begin
          bst_q <= BST_RUN;
        end
        default: begin
          bst_q <= BST_OFF;
        end
      endcase
    end
  end

  // Out-of-range codes map onto the nearest end
  always_comb begin
    if (boost_code_q < VOUT_CODE_MIN) begin
      code_clamped = VOUT_CODE_MIN;
    end else if (boost_code_q > VOUT_CODE_MAX) begin
      code_clamped = VOUT_CODE_MAX;
    end else begin
      code_clamped = boost_code_q;
    end
  end

  assign vout_code = code_clamped;
  assign vout_adaptive = ctrl_q.vout_adaptive;
  assign autoload_on = ctrl_q.autoload_en;
  assign boost_low_current = (bst_q == BST_SOFT);

  // ****************************************************************
  // Switch timing and protection
  // ****************************************************************
  srbc_boost_in_t pin_m_q;       // First synchroniser stage
  srbc_boost_in_t pin_s_q;       // Second synchroniser stage
  logic [6:0] sw_cnt_q;          // Position in the switching period
  logic sw_q;                    // Switch drive
  logic [6:0] on_limit;          // Duty ceiling for this state

  // Comparator outputs are asynchronous to the clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_m_q <= 3'h0;
      pin_s_q <= 3'h0;
    end else begin
      pin_m_q <= boost_pins;
      pin_s_q <= pin_m_q;
    end
  end

  // Free-running period counter keeps the spectrum fixed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_cnt_q <= 7'h00;
    end else if (sw_cnt_q == 7'(SW_PERIOD_CYC - 1)) begin
      sw_cnt_q <= 7'h00;
    end else begin
      sw_cnt_q <= sw_cnt_q + 7'h01;
    end
  end

  assign on_limit = (bst_q == BST_SOFT) ? 7'(SOFT_ON_CYC) : 7'(MAX_ON_CYC);

  // Protection trips override even the minimum pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_q <= 1'b0;
    end else if (bst_q == BST_OFF || pin_s_q.feedback_open) begin
      sw_q <= 1'b0;
    end else if (pin_s_q.switch_overcurrent) begin
      sw_q <= 1'b0;
    end else if (sw_cnt_q == 7'h00) begin
      sw_q <= 1'b1;
    end else if (sw_cnt_q >= on_limit) begin
      sw_q <= 1'b0;
    end else if (sw_cnt_q >= 7'(MIN_PULSE_CYC) && pin_s_q.cur_trip) begin
      sw_q <= 1'b0;
    end
  end

  assign boost_switch = sw_q;

  // ****************************************************************
  // LED PWM cycle timing
  // ****************************************************************
  localparam int PWM_SUB = PWM_LEN / PWM_FAST_MULT;
  logic [16:0] pwm_cnt_q;        // Position in the PWM cycle
  logic [12:0] sub_cnt_q;        // Position in the fast sub-cycle
  logic cyc_q;                   // Cycle start pulse
  logic pulse_q;                 // Pulse start pulse

  // Both counts run from the system clock, so accuracy tracks it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwm_cnt_q <= 17'h0_0000;
      sub_cnt_q <= 13'h0000;
      cyc_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      cyc_q <= 1'b0;
      pulse_q <= 1'b0;
      if (pwm_cnt_q == 17'(PWM_LEN - 1)) begin
        pwm_cnt_q <= 17'h0_0000;
        sub_cnt_q <= 13'h0000;
        cyc_q <= 1'b1;
        pulse_q <= 1'b1;
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 17'h0_0001;
        if (sub_cnt_q == 13'(PWM_SUB - 1)) begin
          sub_cnt_q <= 13'h0000;
          pulse_q <= pwm_fast;
        end else begin
          sub_cnt_q <= sub_cnt_q + 13'h0001;
        end
      end
    end
  end

  assign pwm_cycle_start = cyc_q;
  assign pwm_pulse_start = pulse_q;

endmodule

// ---- inc/srbc_pkg.sv ----
// ****************************************************************
// Shared constants and types
// ****************************************************************
package srbc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;                 // System clock rate in MHz
  localparam int AVG_WIN_MS = 134;              // Averaging window in ms
  localparam int AVG_WIN_CYC = AVG_WIN_MS * CLK_MHZ * 1000;
  localparam int AVG_SAMPLES = 64;              // Samples per channel per window
  localparam int AVG_SHIFT = 6;                 // log2 of AVG_SAMPLES
  localparam int SW_FREQ_MHZ = 1;               // Boost switching rate in MHz
  localparam int SW_PERIOD_CYC = CLK_MHZ / SW_FREQ_MHZ;
  localparam int MIN_PULSE_NS = 50;             // Least inductor pulse in ns
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_DUTY_PCT = 90;             // Duty ceiling in percent
  localparam int MAX_ON_CYC = SW_PERIOD_CYC * MAX_DUTY_PCT / 100;
  localparam int SOFT_DUTY_PCT = 25;            // Duty ceiling in low-current start
  localparam int SOFT_ON_CYC = SW_PERIOD_CYC * SOFT_DUTY_PCT / 100;
  localparam int SOFT_MS = 50;                  // Low-current start time in ms
  localparam int SOFT_CYC = SOFT_MS * CLK_MHZ * 1000;
  localparam int PWM_CYCLE_US = 820;            // LED PWM cycle in us
  localparam int PWM_CYCLE_CYC = PWM_CYCLE_US * CLK_MHZ;
  localparam int PWM_FAST_MULT = 16;            // Fast mode pulses per cycle

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] BOOST_OUTPUT_ADDR = 8'h05;
  localparam logic [7:0] MEASURE_BOOST_CONTROL_ADDR = 8'h06;
  localparam logic [7:0] CONV_UPPER_ADDR = 8'h07;
  localparam logic [7:0] CONV_LOWER_ADDR = 8'h08;
  localparam logic [7:0] CONTROL_RESET = 8'h04;     // Adaptive voltage on
  localparam logic [4:0] BOOST_OUTPUT_RESET = 5'h14;
  localparam logic [4:0] VOUT_CODE_MIN = 5'h05;
  localparam logic [4:0] VOUT_CODE_MAX = 5'h14;

  // ****************************************************************
  // Control register layout
  // ****************************************************************
  typedef struct packed {
    logic [1:0] spare;                    // Bits 7:6, stored only
    logic readout_channel_select;         // Bit 5
    logic compensation_source_choice;     // Bit 4
    logic autoload_en;                    // Bit 3
    logic vout_adaptive;                  // Bit 2
    logic boost_run;                      // Bit 1
    logic chip_active;                    // Bit 0
  } srbc_ctrl_t;

  // Boost pin-side status, bundled as it arrives at the pins, before synchronising
  typedef struct packed {
    logic cur_trip;                       // Inductor current reached target
    logic switch_overcurrent;             // Voltage across switch too high
    logic feedback_open;                  // Feedback pin disconnected
  } srbc_boost_in_t;

endpackage

// ---- rtl/srbc_avg.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Block averager for one sensor input
// ****************************************************************
module srbc_avg
  import srbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic smp_valid,
  input wire logic [11:0] smp_data,
  output logic [11:0] avg_q
);

  logic [17:0] sum_q;          // Running sum of the current block
  logic [5:0] cnt_q;           // Samples taken in the current block

  // Sum a fixed number of samples, then publish the mean
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sum_q <= 18'h0_0000;
      cnt_q <= 6'h00;
      avg_q <= 12'h000;
    end else if (smp_valid) begin
      cnt_q <= cnt_q + 6'h01;
      if (cnt_q == 6'(AVG_SAMPLES - 1)) begin
        // Last sample: power-of-two count keeps the divide a shift
        avg_q <= 12'((sum_q + {6'h00, smp_data}) >> AVG_SHIFT);
        sum_q <= 18'h0_0000;
      end else begin
        sum_q <= sum_q + {6'h00, smp_data};
      end
    end
  end

endmodule

// ---- verification/srbc_conv_model.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Converter stand-in: one shared converter answers each start
// ****************************************************************
module srbc_conv_model #(
  parameter logic [11:0] VAL_ONE = 12'h5A3,  // Level seen on the first sensor
  parameter logic [11:0] VAL_TWO = 12'h3C7   // Level seen on the second sensor
) (
  input wire logic sys_clk,
  input wire logic start,
  input wire logic input_select,
  output logic done,
  output logic [11:0] data
);
  initial begin
    done = 1'b0;
    data = 12'hFFF;
  end
  // Answer three cycles after a start, well before the next one
  always @(posedge sys_clk) begin
    if (start) begin
      repeat (3) @(posedge sys_clk);
      #1;
      done = 1'b1;
      data = input_select ? VAL_TWO : VAL_ONE;  // One converter, two inputs
      @(posedge sys_clk);
      #1;
      done = 1'b0;
      data = ~data;  // Stale data is scrambled so it cannot be mistaken for valid
    end
  end
endmodule

// ---- verification/srbc_core_chk.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Port checker for the readout and boost core
// ****************************************************************
module srbc_core_chk
  import srbc_pkg::*;
#(
  parameter int AVG_WIN = AVG_WIN_CYC,
  parameter int SOFT_LEN = SOFT_CYC,
  parameter int PWM_LEN = PWM_CYCLE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic adc_start,
  input wire logic adc_input_select,
  input wire logic adc_done,
  input wire srbc_boost_in_t boost_pins,
  input wire logic boost_switch,
  input wire logic boost_low_current,
  input wire logic [4:0] vout_code,
  input wire logic pwm_fast,
  input wire logic pwm_cycle_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  int on_cnt_q;    // Consecutive cycles with the switch on
  int per_cnt_q;   // Cycles since the last switch turn-on
  int lc_cnt_q;    // Consecutive cycles of low-current start
  int pc_cnt_q;    // Cycles since the last PWM cycle start
  logic sw_prev_q;
  logic per_seen_q;
  logic pc_seen_q;
  // Run-length counters; cleared by reset so a mid-run reset starts fresh
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      on_cnt_q <= 0;
      per_cnt_q <= 0;
      lc_cnt_q <= 0;
      pc_cnt_q <= 0;
      sw_prev_q <= 1'b0;
      per_seen_q <= 1'b0;
      pc_seen_q <= 1'b0;
    end else begin
      on_cnt_q <= boost_switch ? on_cnt_q + 1 : 0;
      per_cnt_q <= (boost_switch && !sw_prev_q) ? 1 : per_cnt_q + 1;
      per_seen_q <= per_seen_q | (boost_switch && !sw_prev_q);
      sw_prev_q <= boost_switch;
      lc_cnt_q <= boost_low_current ? lc_cnt_q + 1 : 0;
      pc_cnt_q <= pwm_cycle_start ? 1 : pc_cnt_q + 1;
      pc_seen_q <= pc_seen_q | pwm_cycle_start;
    end
  end
  sequence s_fault_held;
    (boost_pins.switch_overcurrent || boost_pins.feedback_open)[*4];
  endsequence
  sequence s_min_on;
    boost_switch[*4];
  endsequence
  a_fault_cuts_switch: assert property (s_fault_held |=> !boost_switch)
    else $error("switch on while a fault is held");
  a_min_pulse_len: assert property (disable iff (rst || boost_pins.switch_overcurrent
      || boost_pins.feedback_open) $rose(boost_switch) |=> s_min_on)
    else $error("switch pulse shorter than the minimum");
  a_duty_ceiling: assert property (boost_switch |->
      on_cnt_q < (boost_low_current ? SOFT_ON_CYC : MAX_ON_CYC))
    else $error("switch on time above its ceiling");
  a_fixed_period: assert property (boost_switch && !sw_prev_q && per_seen_q
      && per_cnt_q < 2 * SW_PERIOD_CYC |-> per_cnt_q == SW_PERIOD_CYC)
    else $error("switch period not fixed");
  a_soft_length: assert property ($fell(boost_low_current) |-> lc_cnt_q == SOFT_LEN)
    else $error("low-current start has wrong length");
  a_pwm_period: assert property (pwm_cycle_start && pc_seen_q |-> pc_cnt_q == PWM_LEN)
    else $error("PWM cycle length wrong");
  a_start_single: assert property (adc_start |=> !adc_start)
    else $error("converter start longer than one cycle");
  a_select_flip: assert property (adc_done |=> adc_input_select != $past(adc_input_select))
    else $error("converter input not alternated");
  a_upper_nibble: assert property (reg_rd && reg_addr == CONV_UPPER_ADDR |=>
      reg_rdata[7:4] == 4'h0)
    else $error("upper result byte has bits above the result");
  a_code_range: assert property (vout_code >= VOUT_CODE_MIN && vout_code <= VOUT_CODE_MAX)
    else $error("voltage code outside its range");
endmodule

// ---- verification/srbc_core_test.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Register-driven test of the readout and boost core
// ****************************************************************
module srbc_core_test;
  import srbc_pkg::*;
  localparam int AVG_W = 12800;  // Shortened averaging window
  localparam int SOFT_W = 200;   // Shortened low-current start
  localparam int PWM_W = 1600;   // Shortened PWM cycle, multiple of 16
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, up, lo;
  logic adc_start, adc_input_select, adc_done;
  logic [11:0] adc_data, comp_value;
  srbc_boost_in_t boost_pins = '0;
  logic boost_switch, boost_low_current, autoload_on, vout_adaptive;
  logic [4:0] vout_code;
  logic pwm_fast = 1'b0;
  logic pwm_cycle_start, pwm_pulse_start;
  int errors = 0;
  int num_checks = 0;
  int c;
  logic [4:0] codes [7] = '{5'h00, 5'h04, 5'h05, 5'h0C, 5'h14, 5'h15, 5'h1F};
  logic [4:0] clamp [7] = '{5'h05, 5'h05, 5'h05, 5'h0C, 5'h14, 5'h14, 5'h14};
  logic [11:0] level [2] = '{12'h5A3, 12'h3C7};
  always #5 sys_clk = ~sys_clk;
  srbc_core #(.AVG_WIN(AVG_W), .SOFT_LEN(SOFT_W), .PWM_LEN(PWM_W)) srbc_core_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_start(adc_start),
    .adc_input_select(adc_input_select), .adc_done(adc_done), .adc_data(adc_data),
    .comp_value(comp_value), .boost_pins(boost_pins), .boost_switch(boost_switch),
    .boost_low_current(boost_low_current), .autoload_on(autoload_on),
    .vout_adaptive(vout_adaptive), .vout_code(vout_code), .pwm_fast(pwm_fast),
    .pwm_cycle_start(pwm_cycle_start), .pwm_pulse_start(pwm_pulse_start));
  srbc_conv_model srbc_conv_model_inst (.sys_clk(sys_clk), .start(adc_start),
    .input_select(adc_input_select), .done(adc_done), .data(adc_data));
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  // Data is taken one cycle after the read edge, as the core registers it
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge sys_clk);
    #1;
    d = reg_rdata;
  endtask
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts over n cycles: 0 switch turn-ons, 1 switch on cycles, 2 cycle starts, 3 pulses
  task automatic count_ev(input int which, input int n, output int cnt);
    logic prev;
    prev = boost_switch;
    cnt = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      case (which)
        0: cnt += int'(boost_switch && !prev);
        1: cnt += int'(boost_switch);
        2: cnt += int'(pwm_cycle_start);
        default: cnt += int'(pwm_pulse_start);
      endcase
      prev = boost_switch;
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized well beyond the roughly 400 us the sequence needs
  initial begin
    #1_000_000;
    errors++;
    final_report();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    reg_read(MEASURE_BOOST_CONTROL_ADDR, up);
    chk_val({4'h0, up}, 12'h004);
    reg_read(BOOST_OUTPUT_ADDR, up);
    chk_val({4'h0, up}, 12'h014);
    chk_val({11'h000, vout_adaptive}, 12'h001);
    reg_write(8'h20, 8'h30);
    reg_read(8'h20, up);
    chk_val({4'h0, up}, 12'h000);
    reg_write(MEASURE_BOOST_CONTROL_ADDR, 8'hC8);
    reg_read(MEASURE_BOOST_CONTROL_ADDR, up);
    chk_val({4'h0, up}, 12'h0C8);
    chk_val({10'h000, autoload_on, vout_adaptive}, 12'h002);
    for (int i = 0; i < 7; i++) begin
      reg_write(BOOST_OUTPUT_ADDR, {3'h0, codes[i]});
      chk_val({7'h00, vout_code}, {7'h00, clamp[i]});
    end
    count_ev(2, 2 * PWM_W, c);
    chk_cnt(c, 2);
    count_ev(3, 2 * PWM_W, c);
    chk_cnt(c, 2);
    pwm_fast = 1'b1;
    repeat (PWM_W) @(posedge sys_clk);
    #1;
    count_ev(3, 2 * PWM_W, c);
    chk_cnt(c, 32);
    repeat (2 * AVG_W) @(posedge sys_clk);
    for (int s = 0; s < 2; s++) begin
      reg_write(MEASURE_BOOST_CONTROL_ADDR, s[0] ? 8'h31 : 8'h01);
      reg_read(CONV_UPPER_ADDR, up);
      reg_read(CONV_LOWER_ADDR, lo);
      chk_val({4'h0, up}, {8'h00, level[s][11:8]});
      chk_val({4'h0, lo}, {4'h0, level[s][7:0]});
      chk_val(comp_value, level[s]);
    end
    // Switch readout after the upper read: the lower byte must stay with sensor one
    reg_write(MEASURE_BOOST_CONTROL_ADDR, 8'h01);
    reg_read(CONV_UPPER_ADDR, up);
    reg_write(MEASURE_BOOST_CONTROL_ADDR, 8'h21);
    reg_read(CONV_LOWER_ADDR, lo);
    chk_val({4'h0, lo}, {4'h0, level[0][7:0]});
    reg_write(MEASURE_BOOST_CONTROL_ADDR, 8'h03);
    repeat (3) @(posedge sys_clk);
    #1;
    chk_val({11'h000, boost_low_current}, 12'h001);
    repeat (SOFT_W + 10) @(posedge sys_clk);
    #1;
    chk_val({11'h000, boost_low_current}, 12'h000);
    count_ev(0, 1000, c);
    chk_cnt(c, 10);
    count_ev(1, 1000, c);
    chk_cnt(int'(c >= 800 && c <= 900), 1);
    boost_pins.cur_trip = 1'b1;
    count_ev(1, 1000, c);
    chk_cnt(int'(c >= 40 && c <= 70), 1);
    boost_pins.cur_trip = 1'b0;
    boost_pins.feedback_open = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    count_ev(1, 300, c);
    chk_cnt(c, 0);
    boost_pins.feedback_open = 1'b0;
    boost_pins.switch_overcurrent = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    count_ev(1, 300, c);
    chk_cnt(c, 0);
    boost_pins.switch_overcurrent = 1'b0;
    count_ev(0, 300, c);
    chk_cnt(int'(c >= 1), 1);
    // Stop in the off part of a period so no pulse is cut short
    @(negedge boost_switch);
    reg_write(MEASURE_BOOST_CONTROL_ADDR, 8'h01);
    repeat (5) @(posedge sys_clk);
    #1;
    count_ev(0, 300, c);
    chk_cnt(c, 0);
    final_report();
  end
endmodule
bind srbc_core srbc_core_chk #(.AVG_WIN(AVG_WIN), .SOFT_LEN(SOFT_LEN), .PWM_LEN(PWM_LEN))
  srbc_core_chk_inst (.sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .adc_start(adc_start), .adc_input_select(adc_input_select),
  .adc_done(adc_done), .boost_pins(boost_pins), .boost_switch(boost_switch),
  .boost_low_current(boost_low_current), .vout_code(vout_code), .pwm_fast(pwm_fast),
  .pwm_cycle_start(pwm_cycle_start));
